// ===== rtl/lpmd_pkg.sv
package lpmd_pkg;

    // register indices on the plain software port (word addressed)
    localparam logic [3:0] REG_LOW_BASE    = 4'h0;
    localparam logic [3:0] REG_LOW_LIMIT   = 4'h1;
    localparam logic [3:0] REG_HIGH_BASE_L = 4'h2;
    localparam logic [3:0] REG_HIGH_BASE_H = 4'h3;
    localparam logic [3:0] REG_HIGH_LIM_L  = 4'h4;
    localparam logic [3:0] REG_HIGH_LIM_H  = 4'h5;
    localparam logic [3:0] REG_CTRL        = 4'h6;
    localparam logic [3:0] REG_STATUS      = 4'h7;
    localparam logic [3:0] REG_LOCAL_CNT   = 4'h8;
    localparam logic [3:0] REG_FWD_CNT     = 4'h9;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // low window: address bits 31:24 come from field bits 15:8
    localparam int LOW_FLD_HI = 15;
    localparam int LOW_FLD_LO = 8;
    localparam int LOW_ADR_LO = 24;

    // high window: field bits 50:26 compared with address bits 63:26
    localparam int HIGH_FLD_HI = 50;
    localparam int HIGH_FLD_LO = 26;
    localparam int HIGH_FLD_W  = HIGH_FLD_HI - HIGH_FLD_LO + 1;
    localparam int HIGH_ADR_HI = 63;

    localparam logic [63:0] HIGH_FIELD_MASK = 64'h0007_FFFF_FC00_0000;

    localparam logic [15:0] LOW_BASE_RST  = 16'h0000;
    localparam logic [15:0] LOW_LIMIT_RST = 16'h0000;
    localparam logic [63:0] HIGH_BASE_RST = 64'h0000_0000_0000_0000;
    localparam logic [63:0] HIGH_LIM_RST  = 64'h0000_0000_0000_0000;

    // control bits
    localparam int CTRL_LOW_EN  = 0;
    localparam int CTRL_HIGH_EN = 1;
    localparam int CTRL_LOCK    = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;

    localparam int CNT_W = 32;

    typedef enum logic [1:0] {
        LPMD_ROUTE_NONE,
        LPMD_ROUTE_LOCAL,
        LPMD_ROUTE_RING
    } lpmd_route_e;

endpackage : lpmd_pkg

// ===== rtl/lpmd_range_cmp.sv
`timescale 1ns/100ps
// inclusive base <= value <= limit check; empty when base > limit
module lpmd_range_cmp #(
    parameter int W = 8
) (
    // operands
    input  wire logic [W-1:0] base,
    input  wire logic [W-1:0] limit,
    input  wire logic [W-1:0] value,
    // result
    output logic              hit,
    output logic              empty
);
    assign empty = base > limit;
    assign hit   = (base <= value) && (value <= limit);
endmodule : lpmd_range_cmp

// ===== rtl/lpmd_evt_cnt.sv
`timescale 1ns/100ps
// saturating event counter, software clears with a write
module lpmd_evt_cnt #(
    parameter int W = 32
) (
    // clocking
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    // events
    input  wire logic         inc,
    input  wire logic         clr,
    output logic [W-1:0]      count_r
);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_r <= '0;
        end else if (ce) begin
            // a clear and a new event in the same cycle restart the count at one
            if (inc && clr) begin
                count_r <= {{(W-1){1'b0}}, 1'b1};
            end else if (clr) begin
                count_r <= '0;
            end else if (inc && !(&count_r)) begin
                count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule : lpmd_evt_cnt

// ===== rtl/lpmd_decode.sv
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
// How it works
// R1: only software-programmed base/limit pairs create a local window.
// R2: a request inside a local window is never routed to the ring.
// R3: 32-bit requests use the low pair, 64-bit requests the high pair.
// R4: low window spans base[15:8] with zeros up to limit[15:8] with ones.
// R5: high match when base[50:26] <= addr[63:26] <= limit[50:26].
// R6: a high base above the high limit disables high decoding.
// R7: software writes the high limit once at boot and leaves it.
// R8: reserved bits of the high limit read zero and ignore writes.
module lpmd_decode
    import lpmd_pkg::*;
(
    // clocking
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      ce,
    // register port
    input  wire logic [lpmd_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [lpmd_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [lpmd_pkg::DATA_W-1:0]    reg_rdata,
    // inbound request from a root port
    input  wire logic                      req_valid,
    input  wire logic [63:0]               req_addr,
    input  wire logic                      req_is64,
    // routing decision
    output logic                           route_valid,
    output logic                           route_local,
    output logic                           route_ring,
    output logic [63:0]                    route_addr
);
    import lpmd_pkg::*;

    logic [15:0]       low_base_r;
    logic [15:0]       low_limit_r;
    logic [63:0]       high_base_r;
    logic [63:0]       high_lim_r;
    logic [2:0]        ctrl_r;
    logic              low_prog_r;
    logic              high_prog_r;
    logic              lim_written_r;
    logic [DATA_W-1:0] reg_rdata_nxt;
    logic              low_hit;
    logic              low_empty;
    logic              high_hit;
    logic              high_empty;
    logic              low_match;
    logic              high_match;
    logic              is_local;
    logic              locked;
    logic [CNT_W-1:0]  local_cnt;
    logic [CNT_W-1:0]  fwd_cnt;
    logic              wr_base_h;
    logic              wr_lim;

    assign locked    = ctrl_r[CTRL_LOCK];
    assign wr_base_h = reg_wr && !locked &&
                       (reg_addr == REG_HIGH_BASE_L ||
                        reg_addr == REG_HIGH_BASE_H);
    assign wr_lim    = reg_wr && !locked &&
                       (reg_addr == REG_HIGH_LIM_L ||
                        reg_addr == REG_HIGH_LIM_H);

    // low window registers; lock bit makes the windows read only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_base_r  <= LOW_BASE_RST;
            low_limit_r <= LOW_LIMIT_RST;
            low_prog_r  <= 1'b0;
        end else if (ce && reg_wr && !locked) begin
            if (reg_addr == REG_LOW_BASE) begin
                low_base_r <= reg_wdata[15:0];
                low_prog_r <= 1'b1; // see R1
            end
            if (reg_addr == REG_LOW_LIMIT) begin
                low_limit_r <= reg_wdata[15:0];
            end
        end
    end

    // high window registers; only field bits are stored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            high_base_r <= HIGH_BASE_RST;
            high_lim_r  <= HIGH_LIM_RST;
            high_prog_r <= 1'b0;
        end else if (ce) begin
            if (wr_base_h && reg_addr == REG_HIGH_BASE_L) begin
                high_base_r[31:0] <= reg_wdata & HIGH_FIELD_MASK[31:0];
                high_prog_r <= 1'b1; // see R1
            end
            if (wr_base_h && reg_addr == REG_HIGH_BASE_H) begin
                high_base_r[63:32] <= reg_wdata & HIGH_FIELD_MASK[63:32];
                high_prog_r <= 1'b1; // see R1
            end
            if (wr_lim && reg_addr == REG_HIGH_LIM_L) begin
                high_lim_r[31:0] <= reg_wdata & HIGH_FIELD_MASK[31:0]; // see R8
            end
            if (wr_lim && reg_addr == REG_HIGH_LIM_H) begin
                high_lim_r[63:32] <= reg_wdata & HIGH_FIELD_MASK[63:32]; // see R8
            end
        end
    end

    // flag any write of the high limit since reset, the first one included (R7)
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lim_written_r <= 1'b0;
        end else if (ce && wr_lim) begin
            lim_written_r <= 1'b1; // see R7
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_r <= CTRL_RST;
        end else if (ce && reg_wr && reg_addr == REG_CTRL) begin
            // lock is sticky until reset
            ctrl_r <= {reg_wdata[CTRL_LOCK] | ctrl_r[CTRL_LOCK],
                       reg_wdata[CTRL_HIGH_EN], reg_wdata[CTRL_LOW_EN]};
        end
    end

    lpmd_range_cmp #(
        .W (LOW_FLD_HI - LOW_FLD_LO + 1)
    ) u_low_cmp (
        .base  (low_base_r[LOW_FLD_HI:LOW_FLD_LO]),
        .limit (low_limit_r[LOW_FLD_HI:LOW_FLD_LO]),
        .value (req_addr[31:LOW_ADR_LO]), // see R4
        .hit   (low_hit),
        .empty (low_empty)
    );

    // the high address beyond bit 50 of the field is compared zero extended
    lpmd_range_cmp #(
        .W (HIGH_ADR_HI - HIGH_FLD_LO + 1)
    ) u_high_cmp (
        .base  ({13'h0, high_base_r[HIGH_FLD_HI:HIGH_FLD_LO]}),
        .limit ({13'h0, high_lim_r[HIGH_FLD_HI:HIGH_FLD_LO]}),
        .value (req_addr[HIGH_ADR_HI:HIGH_FLD_LO]), // see R5
        .hit   (high_hit),
        .empty (high_empty)
    );

    // 32-bit requests only see the low pair, 64-bit the high pair
    assign low_match  = !req_is64 && low_prog_r && ctrl_r[CTRL_LOW_EN] &&
                        low_hit && (req_addr[63:32] == 32'h0000_0000); // see R3
    assign high_match = req_is64 && high_prog_r && ctrl_r[CTRL_HIGH_EN] &&
                        !high_empty && high_hit; // see R3 see R6
    assign is_local   = low_match || high_match;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            route_valid <= 1'b0;
            route_local <= 1'b0;
            route_ring  <= 1'b0;
            route_addr  <= 64'h0000_0000_0000_0000;
        end else if (ce) begin
            route_valid <= req_valid;
            route_local <= req_valid && is_local;  // see R2
            route_ring  <= req_valid && !is_local; // see R2
            if (req_valid) begin
                route_addr <= req_addr;
            end
        end
    end

    lpmd_evt_cnt #(
        .W (CNT_W)
    ) u_local_cnt (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .inc     (req_valid && is_local),
        .clr     (reg_wr && reg_addr == REG_LOCAL_CNT),
        .count_r (local_cnt)
    );

    lpmd_evt_cnt #(
        .W (CNT_W)
    ) u_fwd_cnt (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .inc     (req_valid && !is_local),
        .clr     (reg_wr && reg_addr == REG_FWD_CNT),
        .count_r (fwd_cnt)
    );

    always_comb begin
        reg_rdata_nxt = '0;
        unique case (reg_addr)
            REG_LOW_BASE:    reg_rdata_nxt = {16'h0000, low_base_r};
            REG_LOW_LIMIT:   reg_rdata_nxt = {16'h0000, low_limit_r};
            REG_HIGH_BASE_L: reg_rdata_nxt = high_base_r[31:0];
            REG_HIGH_BASE_H: reg_rdata_nxt = high_base_r[63:32];
            REG_HIGH_LIM_L:  reg_rdata_nxt = high_lim_r[31:0];
            REG_HIGH_LIM_H:  reg_rdata_nxt = high_lim_r[63:32];
            REG_CTRL:        reg_rdata_nxt = {29'h0, ctrl_r};
            REG_STATUS:      reg_rdata_nxt = {28'h0000_000, lim_written_r,
                                              high_empty, high_prog_r,
                                              low_prog_r};
            REG_LOCAL_CNT:   reg_rdata_nxt = local_cnt;
            REG_FWD_CNT:     reg_rdata_nxt = fwd_cnt;
            default:         reg_rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= reg_rd ? reg_rdata_nxt : '0;
        end
    end

    // helper copies of the stored high window for the properties
    logic [63:0] s_base;
    logic [63:0] s_lim;
    assign s_base = high_base_r;
    assign s_lim  = high_lim_r;

    property p_never_both;
        @(posedge clk) disable iff (sys_rst)
        !(route_local && route_ring);
    endproperty
    a_never_both: assert property (p_never_both) // see R2
        else $error("request routed both local and to ring");

    property p_local_not_ring;
        @(posedge clk) disable iff (sys_rst)
        (ce && req_valid && is_local) |=> (route_local && !route_ring);
    endproperty
    a_local_not_ring: assert property (p_local_not_ring) // see R2
        else $error("local request forwarded to ring");

    property p_unprog_ring;
        @(posedge clk) disable iff (sys_rst)
        (ce && req_valid && !low_prog_r && !high_prog_r) |=> route_ring;
    endproperty
    a_unprog_ring: assert property (p_unprog_ring) // see R1
        else $error("local claim without programmed window");

    property p_high_disabled;
        @(posedge clk) disable iff (sys_rst)
        (ce && req_valid && req_is64 &&
         s_base[50:26] > s_lim[50:26]) |=> !route_local;
    endproperty
    a_high_disabled: assert property (p_high_disabled) // see R6
        else $error("high window matched with base above limit");

    property p_high_range;
        @(posedge clk) disable iff (sys_rst)
        (ce && req_valid && req_is64 && high_prog_r && ctrl_r[1] &&
         s_base[50:26] <= req_addr[63:26] &&
         {13'h0, s_lim[50:26]} >= req_addr[63:26]) |=> route_local;
    endproperty
    a_high_range: assert property (p_high_range) // see R5
        else $error("high window hit not claimed locally");

    property p_low_range;
        @(posedge clk) disable iff (sys_rst)
        (ce && req_valid && !req_is64 && low_prog_r && ctrl_r[0] &&
         req_addr[63:32] == 32'h0 &&
         req_addr[31:24] >= low_base_r[15:8] &&
         req_addr[31:24] <= low_limit_r[15:8]) |=> route_local;
    endproperty
    a_low_range: assert property (p_low_range) // see R4
        else $error("low window hit not claimed locally");

    property p_type_select;
        @(posedge clk) disable iff (sys_rst)
        (ce && req_valid && req_is64 && !high_match) |=> route_ring;
    endproperty
    a_type_select: assert property (p_type_select) // see R3
        else $error("64-bit request claimed by low window");

    property p_reserved_zero;
        @(posedge clk) disable iff (sys_rst)
        ##1 ((s_lim & ~HIGH_FIELD_MASK) == 64'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // see R8
        else $error("reserved limit bits not zero");

    property p_read_latency;
        @(posedge clk) disable iff (sys_rst)
        (ce && reg_rd && reg_addr == REG_HIGH_LIM_H) |=>
            (reg_rdata == $past(s_lim[63:32]));
    endproperty
    a_read_latency: assert property (p_read_latency) // see R8
        else $error("limit read data wrong");

    property p_idle_quiet;
        @(posedge clk) disable iff (sys_rst)
        (ce && !req_valid) |=> (!route_valid && !route_local && !route_ring);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) // see R2
        else $error("route decision without a request");

    property p_low_lim_reserved;
        @(posedge clk) disable iff (sys_rst)
        (ce && reg_rd && reg_addr == REG_HIGH_LIM_L) |=>
            (reg_rdata[25:0] == 26'h0);
    endproperty
    a_low_lim_reserved: assert property (p_low_lim_reserved) // see R8
        else $error("reserved low limit bits read nonzero");

endmodule : lpmd_decode

// ===== test/lpmd_far_model.sv
`timescale 1ns/100ps
// root-port agents and the coherent ring, seen from the routing outputs
module lpmd_far_model (
    // clocking
    input  wire logic clk,
    input  wire logic sys_rst,
    // routing decision
    input  wire logic route_valid,
    input  wire logic route_local,
    input  wire logic route_ring,
    // tallies
    output int        claim_cnt,
    output int        ring_cnt,
    output int        clash_cnt
);
    // the local agent claims and answers; the ring sees only the remainder
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            claim_cnt <= 0;
            ring_cnt  <= 0;
            clash_cnt <= 0;
        end else if (route_valid) begin
            if (route_local)
                claim_cnt <= claim_cnt + 1;
            if (route_ring)
                ring_cnt <= ring_cnt + 1;
            // a request both claimed and sent to the ring, or sent to neither, is a clash
            if (route_local == route_ring)
                clash_cnt <= clash_cnt + 1;
        end else if (route_local || route_ring) begin
            // a decision with no request behind it is a stray answer
            clash_cnt <= clash_cnt + 1;
        end
    end
endmodule : lpmd_far_model

// ===== test/local_peer_mmio_decode_tb.sv
`timescale 1ns/100ps
module local_peer_mmio_decode_tb;
    import lpmd_pkg::*;

    typedef struct packed {
        logic        is64;
        logic [63:0] addr;
        logic        loc;
    } lpmd_row_s;

    logic        clk;
    logic        sys_rst;
    logic        ce;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        req_valid;
    logic [63:0] req_addr;
    logic        req_is64;
    logic        route_valid;
    logic        route_local;
    logic        route_ring;
    logic [63:0] route_addr;
    int          claim_cnt;
    int          ring_cnt;
    int          clash_cnt;
    int          fails;
    int          checked;
    int          cycles;
    lpmd_row_s   rows [10];

    lpmd_decode dut_u (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .ce          (ce),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_rdata   (reg_rdata),
        .req_valid   (req_valid),
        .req_addr    (req_addr),
        .req_is64    (req_is64),
        .route_valid (route_valid),
        .route_local (route_local),
        .route_ring  (route_ring),
        .route_addr  (route_addr)
    );

    lpmd_far_model far_u (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .route_valid (route_valid),
        .route_local (route_local),
        .route_ring  (route_ring),
        .claim_cnt   (claim_cnt),
        .ring_cnt    (ring_cnt),
        .clash_cnt   (clash_cnt)
    );

    task give_verdict;
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(64'(reg_rdata), 64'(exp));
    endtask : rd

    task send(input logic is64, input logic [63:0] a, input logic loc);
        @(posedge clk);
        req_valid <= 1'b1;
        req_addr  <= a;
        req_is64  <= is64;
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        chk(64'({route_valid, route_local, route_ring}),
            64'({1'b1, loc, ~loc}));
        chk(route_addr, a);
    endtask : send

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        // well above the roughly one hundred cycles the sequence needs
        if (cycles == 5000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        sys_rst   = 1'b1;
        ce        = 1'b1;
        reg_addr  = 4'h0;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        req_valid = 1'b0;
        req_addr  = 64'h0000_0000_0000_0000;
        req_is64  = 1'b0;
        fails     = 0;
        checked   = 0;
        cycles    = 0;
        rows = '{'{1'b0, 64'h0000_0000_FE00_0000, 1'b1},
                 '{1'b0, 64'h0000_0000_FFFF_FFFF, 1'b1},
                 '{1'b0, 64'h0000_0000_FDFF_FFFF, 1'b0},
                 '{1'b0, 64'h0000_0001_FE00_0000, 1'b0},
                 '{1'b1, 64'h0000_0000_FE00_0000, 1'b0},
                 '{1'b1, 64'h0000_0010_0000_0000, 1'b1},
                 '{1'b1, 64'h0000_000F_FFFF_FFFF, 1'b0},
                 '{1'b1, 64'h0000_0020_FFFF_FFFF, 1'b1},
                 '{1'b1, 64'h0000_0021_0000_0000, 1'b0},
                 '{1'b1, 64'h0010_0010_0000_0000, 1'b0}};
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 10; i++)
            rd(i[3:0], 32'h0000_0000);
        wr(REG_CTRL, 32'h0000_0003);
        // enables alone open no window until the bases are written
        send(1'b0, 64'h0000_0000_FE00_0000, 1'b0);
        send(1'b1, 64'h0000_0010_0000_0000, 1'b0);
        wr(REG_LOW_BASE, 32'h0000_FE00);
        wr(REG_LOW_LIMIT, 32'h0000_FF00);
        wr(REG_HIGH_BASE_L, 32'h0000_0000);
        wr(REG_HIGH_BASE_H, 32'h0000_0010);
        wr(REG_HIGH_LIM_L, 32'hFFFF_FFFF);
        wr(REG_HIGH_LIM_H, 32'hFFF8_0020);
        rd(REG_HIGH_LIM_L, 32'hFC00_0000);
        rd(REG_HIGH_LIM_H, 32'h0000_0020);
        for (int i = 0; i < 10; i++)
            send(rows[i].is64, rows[i].addr, rows[i].loc);
        wr(REG_HIGH_BASE_H, 32'h0000_0030);
        send(1'b1, 64'h0000_0020_0000_0000, 1'b0);
        rd(REG_STATUS, 32'h0000_000F);
        rd(REG_LOCAL_CNT, 32'h0000_0004);
        rd(REG_FWD_CNT, 32'h0000_0009);
        chk(64'(claim_cnt), 64'h4);
        chk(64'(ring_cnt), 64'h9);
        chk(64'(clash_cnt), 64'h0);
        // with the clock enable low a write must not land
        @(posedge clk);
        ce <= 1'b0;
        wr(REG_LOW_LIMIT, 32'h0000_0000);
        ce <= 1'b1;
        rd(REG_LOW_LIMIT, 32'h0000_FF00);
        // once locked the windows ignore software
        wr(REG_CTRL, 32'h0000_0007);
        wr(REG_LOW_BASE, 32'h0000_0000);
        rd(REG_LOW_BASE, 32'h0000_FE00);
        rd(4'hA, 32'h0000_0000);
        // a mid-run reset clears the lock, the windows and the counters
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        rd(REG_CTRL, 32'h0000_0000);
        rd(REG_STATUS, 32'h0000_0000);
        rd(REG_LOCAL_CNT, 32'h0000_0000);
        send(1'b0, 64'h0000_0000_FE00_0000, 1'b0);
        give_verdict();
    end
endmodule : local_peer_mmio_decode_tb
